// [rtl/pacd_pkg.sv]
package pacd_pkg;

  typedef enum logic [1:0] {PACD_LVL_LOW, PACD_LVL_OPEN, PACD_LVL_HIGH} pacd_level_t;

  // Register byte offsets
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h8;
  localparam logic [3:0] REG_INFO = 4'hC;

  // Status and mask bit positions
  localparam int ST_COMM_FAULT = 0;
  localparam int ST_STORE = 1;
  localparam int ST_RESTORE = 2;
  localparam int ST_CMD_SEEN = 3;
  localparam int ST_WIDTH = 4;

  // Control bit positions
  localparam int CT_ENABLE = 0;
  localparam int CT_ADAPTIVE = 1;
  localparam int CT_NO_HIGH_STRAP = 2;
  localparam int CT_WIDTH = 3;

  // Reset values
  localparam logic [ST_WIDTH-1:0] STATUS_RST = 4'h0;
  localparam logic [ST_WIDTH-1:0] MASK_RST = 4'h0;
  localparam logic [CT_WIDTH-1:0] CTRL_RST = 3'h1;

  // Cycles after reset before the synchronised straps are valid
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // Strap address map
  localparam logic [6:0] ADDR_BASE = 7'h20;
  localparam int BITS_PER_BYTE = 8;

  // Supervisory and variant command codes
  localparam logic [7:0] CMD_STORE_DEFAULT_ALL = 8'h11;
  localparam logic [7:0] CMD_RESTORE_DEFAULT_ALL = 8'h12;
  localparam logic [7:0] CMD_STORE_USER_ALL = 8'h15;
  localparam logic [7:0] CMD_RESTORE_USER_ALL = 8'h16;
  localparam logic [7:0] FILTER_TAP_CALC_CMD = 8'hF2;
  localparam logic [7:0] CURRENT_SENSE_OFFSET_CMD = 8'hBE;
  localparam logic [7:0] COMP_CONTROL_CMD = 8'hBD;
  localparam logic [7:0] COMP_CONFIG_CMD = 8'hBC;
  localparam logic [7:0] ACCESS_LEVEL_CMD = 8'hFA;

  // Pin pair: bit 0 reads tied to reference, bit 1 reads logic high
  function automatic pacd_level_t level_of(input logic [1:0] pin);
    if (pin[1]) begin
      return PACD_LVL_HIGH;
    end else if (pin[0]) begin
      return PACD_LVL_LOW;
    end
    return PACD_LVL_OPEN;
  endfunction

  // Strap levels to address, both high is reserved
  function automatic logic [7:0] strap_addr(input pacd_level_t lo, input pacd_level_t hi);
    logic [6:0] idx;
    idx = 7'(3 * int'(hi) + int'(lo));
    return {(hi != PACD_LVL_HIGH) || (lo != PACD_LVL_HIGH), 7'(ADDR_BASE + idx)};
  endfunction

  // Implemented command set
  function automatic logic cmd_supported(input logic [7:0] code, input logic adaptive);
    case (code)
      8'h01, 8'h02, 8'h03, 8'h11, 8'h12, 8'h15, 8'h16,
      8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28,
      8'h32, 8'h33, 8'h37, 8'h38, 8'h39,
      8'h40, 8'h41, 8'h44, 8'h45, 8'h46, 8'h4B, 8'h4F,
      8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5A, 8'h5E,
      8'h60, 8'h61, 8'h64, 8'h65,
      8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h80,
      8'h88, 8'h8B, 8'h8C, 8'h8D, 8'h94, 8'h95,
      8'h98, 8'h99, 8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'h9E,
      8'hB0, 8'hBF, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'hD8,
      8'hDC, 8'hDD, 8'hDE, 8'hE0, 8'hE1, 8'hE2, 8'hE4, 8'hE5, 8'hE6, 8'hE7, 8'hE8,
      8'hE9, 8'hEA, 8'hF0, 8'hF3, 8'hFA, 8'hFB, 8'hFC, 8'hFD: return 1'b1;
      FILTER_TAP_CALC_CMD, CURRENT_SENSE_OFFSET_CMD: return !adaptive;
      COMP_CONTROL_CMD, COMP_CONFIG_CMD: return adaptive;
      default: return 1'b0;
    endcase
  endfunction

endpackage

// [rtl/pacd_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module pacd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  initial begin
    if (WIDTH < 1) begin
      $error("pacd_sync width must be positive");
    end
  end

  // Two flops; the first is read only by the second
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign q_out = sync_ff;
endmodule // pacd_sync
`default_nettype wire

// [rtl/pacd_top.sv]
`timescale 1ns/1ns
`default_nettype none
module pacd_top (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [3:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  output logic IRQ_OUT,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  input wire logic [1:0] ADDR_STRAP_LOW_PIN_IN,
  input wire logic [1:0] ADDR_STRAP_HIGH_PIN_IN,
  output logic CMD_VALID_OUT,
  output logic [7:0] CMD_CODE_OUT,
  output logic USER_STORE_OUT
);
  typedef enum logic [2:0] {
    PACD_IDLE, PACD_ADDR, PACD_ADDR_ACK, PACD_CMD, PACD_CMD_ACK, PACD_DATA, PACD_DATA_ACK, PACD_SKIP
  } pacd_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [5:0] pins_s;
  logic scl_s, sda_s;
  logic [1:0] lo_pin_s, hi_pin_s;

  pacd_sync #(.WIDTH(6)) u_sync (
    .CLK_IN(CLK_IN),
    .RST_IN(RST_IN),
    .d_in({ADDR_STRAP_HIGH_PIN_IN, ADDR_STRAP_LOW_PIN_IN, SDA_IN, SCL_IN}),
    .q_out(pins_s)
  );
  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign lo_pin_s = pins_s[3:2];
  assign hi_pin_s = pins_s[5:4];

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  localparam int ST_WIDTH_L = pacd_pkg::ST_WIDTH;
  localparam int CT_WIDTH_L = pacd_pkg::CT_WIDTH;
  pacd_state_t state_ff, nxt_state;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic sda_oe_ff, nxt_sda_oe;
  logic rd_ff, nxt_rd;
  logic scl_d_ff, sda_d_ff;
  logic cmd_valid_ff, nxt_cmd_valid;
  logic [7:0] cmd_code_ff, nxt_cmd_code;
  logic user_store_ff, nxt_user_store;
  logic fault_ev, store_ev, restore_ev;
  logic [ST_WIDTH_L-1:0] status_ff, nxt_status;
  logic [ST_WIDTH_L-1:0] mask_ff, nxt_mask;
  logic [CT_WIDTH_L-1:0] ctrl_ff, nxt_ctrl;
  logic [1:0] lo_lvl_ff, nxt_lo_lvl, hi_lvl_ff, nxt_hi_lvl;
  logic strap_done_ff, nxt_strap_done;
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic irq_ff, nxt_irq;
  logic [1:0] strap_wait_ff, nxt_strap_wait;

  ////////////////////////////////////////////////////////////////////////////
  // Address from straps
  pacd_pkg::pacd_level_t lo_lvl, hi_lvl;
  logic [7:0] addr_info;
  logic addr_valid;
  logic [6:0] dev_addr;
  logic adaptive;
  logic scl_rise, scl_fall, start_cond, stop_cond, byte_done, cmd_ok;

  always_comb begin
    lo_lvl = pacd_pkg::pacd_level_t'(lo_lvl_ff);
    hi_lvl = pacd_pkg::pacd_level_t'(hi_lvl_ff);
    if (ctrl_ff[pacd_pkg::CT_NO_HIGH_STRAP]) begin
      hi_lvl = pacd_pkg::PACD_LVL_OPEN;
    end
  end

  assign addr_info = pacd_pkg::strap_addr(lo_lvl, hi_lvl);
  assign addr_valid = addr_info[7] & strap_done_ff;
  assign dev_addr = addr_info[6:0];
  assign adaptive = ctrl_ff[pacd_pkg::CT_ADAPTIVE];

  ////////////////////////////////////////////////////////////////////////////
  // Link decode
  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_cond = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_cond = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  assign byte_done = scl_fall && (bit_cnt_ff == 4'(pacd_pkg::BITS_PER_BYTE));
  assign cmd_ok = pacd_pkg::cmd_supported(shift_ff, adaptive);

  always_comb begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_rd = rd_ff;
    nxt_cmd_valid = 1'b0;
    nxt_cmd_code = cmd_code_ff;
    nxt_user_store = 1'b0;
    fault_ev = 1'b0;
    store_ev = 1'b0;
    restore_ev = 1'b0;
    if (stop_cond) begin
      nxt_state = PACD_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (start_cond) begin
      nxt_state = PACD_ADDR;
      nxt_bit_cnt = 4'h0;
      nxt_sda_oe = 1'b0;
    end else begin
      case (state_ff)
        PACD_ADDR, PACD_CMD, PACD_DATA: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (byte_done) begin
            nxt_bit_cnt = 4'h0;
            if (state_ff == PACD_ADDR) begin
              if (addr_valid && ctrl_ff[pacd_pkg::CT_ENABLE] && shift_ff[7:1] == dev_addr) begin
                nxt_sda_oe = 1'b1;
                nxt_rd = shift_ff[0];
                nxt_state = PACD_ADDR_ACK;
              end else begin
                nxt_state = PACD_SKIP;
              end
            end else if (state_ff == PACD_CMD) begin
              if (cmd_ok) begin
                nxt_sda_oe = 1'b1;
                nxt_cmd_valid = 1'b1;
                nxt_cmd_code = shift_ff;
                nxt_state = PACD_CMD_ACK;
                store_ev = shift_ff == pacd_pkg::CMD_STORE_USER_ALL ||
                           shift_ff == pacd_pkg::CMD_STORE_DEFAULT_ALL;
                restore_ev = shift_ff == pacd_pkg::CMD_RESTORE_USER_ALL ||
                             shift_ff == pacd_pkg::CMD_RESTORE_DEFAULT_ALL;
                nxt_user_store = shift_ff == pacd_pkg::CMD_STORE_USER_ALL;
              end else begin
                fault_ev = 1'b1;
                nxt_state = PACD_SKIP;
              end
            end else begin
              nxt_sda_oe = 1'b1;
              nxt_state = PACD_DATA_ACK;
            end
          end
        end
        PACD_ADDR_ACK, PACD_CMD_ACK, PACD_DATA_ACK: begin
          if (scl_fall) begin
            nxt_sda_oe = 1'b0;
            if (state_ff == PACD_ADDR_ACK) begin
              nxt_state = rd_ff ? PACD_SKIP : PACD_CMD;
            end else begin
              nxt_state = PACD_DATA;
            end
          end
        end
        default: begin
          nxt_state = state_ff;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      state_ff <= PACD_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      sda_oe_ff <= 1'b0;
      rd_ff <= 1'b0;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      cmd_valid_ff <= 1'b0;
      cmd_code_ff <= 8'h00;
      user_store_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      sda_oe_ff <= nxt_sda_oe;
      rd_ff <= nxt_rd;
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      cmd_valid_ff <= nxt_cmd_valid;
      cmd_code_ff <= nxt_cmd_code;
      user_store_ff <= nxt_user_store;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave, straps, status
  logic wb_req, wb_wr;

  assign wb_req = WB_CYC_IN & WB_STB_IN & ~ack_ff;
  assign wb_wr = wb_req & WB_WE_IN & WB_SEL_IN[0];

  always_comb begin
    nxt_ack = wb_req;
    nxt_dat = 32'h0000_0000;
    nxt_mask = mask_ff;
    nxt_ctrl = ctrl_ff;
    nxt_status = status_ff;
    nxt_lo_lvl = lo_lvl_ff;
    nxt_hi_lvl = hi_lvl_ff;
    nxt_strap_done = strap_done_ff;
    nxt_strap_wait = strap_done_ff ? strap_wait_ff : strap_wait_ff + 2'h1;
    if (!strap_done_ff && strap_wait_ff == pacd_pkg::STRAP_SETTLE) begin
      nxt_lo_lvl = pacd_pkg::level_of(lo_pin_s);
      nxt_hi_lvl = pacd_pkg::level_of(hi_pin_s);
      nxt_strap_done = 1'b1;
    end
    if (wb_wr && WB_ADR_IN == pacd_pkg::REG_STATUS) begin
      nxt_status = status_ff & ~WB_DAT_IN[ST_WIDTH_L-1:0];
    end
    if (wb_wr && WB_ADR_IN == pacd_pkg::REG_MASK) begin
      nxt_mask = WB_DAT_IN[ST_WIDTH_L-1:0];
    end
    if (wb_wr && WB_ADR_IN == pacd_pkg::REG_CTRL) begin
      nxt_ctrl = WB_DAT_IN[CT_WIDTH_L-1:0];
    end
    nxt_status[pacd_pkg::ST_COMM_FAULT] = nxt_status[pacd_pkg::ST_COMM_FAULT] | fault_ev;
    nxt_status[pacd_pkg::ST_STORE] = nxt_status[pacd_pkg::ST_STORE] | store_ev;
    nxt_status[pacd_pkg::ST_RESTORE] = nxt_status[pacd_pkg::ST_RESTORE] | restore_ev;
    nxt_status[pacd_pkg::ST_CMD_SEEN] = nxt_status[pacd_pkg::ST_CMD_SEEN] | nxt_cmd_valid;
    if (wb_req && !WB_WE_IN) begin
      case (WB_ADR_IN)
        pacd_pkg::REG_STATUS: nxt_dat = 32'(status_ff);
        pacd_pkg::REG_MASK: nxt_dat = 32'(mask_ff);
        pacd_pkg::REG_CTRL: nxt_dat = 32'(ctrl_ff);
        pacd_pkg::REG_INFO: nxt_dat = {16'h0000, cmd_code_ff, addr_valid, dev_addr};
        default: nxt_dat = 32'h0000_0000;
      endcase
    end
    nxt_irq = |(nxt_status & nxt_mask);
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
      mask_ff <= pacd_pkg::MASK_RST;
      ctrl_ff <= pacd_pkg::CTRL_RST;
      status_ff <= pacd_pkg::STATUS_RST;
      lo_lvl_ff <= 2'h1;
      hi_lvl_ff <= 2'h1;
      strap_done_ff <= 1'b0;
      strap_wait_ff <= 2'h0;
      irq_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      mask_ff <= nxt_mask;
      ctrl_ff <= nxt_ctrl;
      status_ff <= nxt_status;
      lo_lvl_ff <= nxt_lo_lvl;
      hi_lvl_ff <= nxt_hi_lvl;
      strap_done_ff <= nxt_strap_done;
      strap_wait_ff <= nxt_strap_wait;
      irq_ff <= nxt_irq;
    end
  end

  assign WB_ACK_OUT = ack_ff;
  assign WB_DAT_OUT = dat_ff;
  assign IRQ_OUT = irq_ff;
  assign SDA_OUT = 1'b0;
  assign SDA_OE_OUT = sda_oe_ff;
  assign CMD_VALID_OUT = cmd_valid_ff;
  assign CMD_CODE_OUT = cmd_code_ff;
  assign USER_STORE_OUT = user_store_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_addr_map: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    addr_valid |-> dev_addr == 7'(7'h20 + 3 * int'(hi_lvl) + int'(lo_lvl))) else $error("Strap address wrong");
  a_addr_reserved: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (lo_lvl == pacd_pkg::PACD_LVL_HIGH && hi_lvl == pacd_pkg::PACD_LVL_HIGH) |-> !addr_valid)
    else $error("Reserved strap answered");
  a_no_high_open: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (ctrl_ff[pacd_pkg::CT_NO_HIGH_STRAP] && strap_done_ff) |-> addr_valid && dev_addr >= 7'h23 && dev_addr <= 7'h25)
    else $error("Missing strap not open");
  a_unsup_nack: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (state_ff == PACD_CMD && byte_done && !cmd_ok && !stop_cond && !start_cond) |=> !sda_oe_ff && state_ff == PACD_SKIP)
    else $error("Unsupported command acknowledged");
  a_fault_sticky: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    fault_ev |=> status_ff[pacd_pkg::ST_COMM_FAULT] ##1 (status_ff[pacd_pkg::ST_COMM_FAULT] || $past(wb_wr)))
    else $error("Fault not recorded");
  a_variant_codes: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    cmd_valid_ff |-> !($past(adaptive) && cmd_code_ff == pacd_pkg::FILTER_TAP_CALC_CMD))
    else $error("Variant code accepted");
  a_store_event: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    user_store_ff |-> cmd_valid_ff && cmd_code_ff == pacd_pkg::CMD_STORE_USER_ALL && status_ff[pacd_pkg::ST_STORE])
    else $error("User store without command");
  a_ack_single: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    WB_ACK_OUT |-> $past(wb_req) ##1 !WB_ACK_OUT) else $error("Bus ack not single");
  a_irq_level: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    ##1 IRQ_OUT == |(status_ff & mask_ff)) else $error("Interrupt level wrong");
  a_ack_release: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (sda_oe_ff && scl_fall && !stop_cond && !start_cond && state_ff != PACD_ADDR && state_ff != PACD_CMD
     && state_ff != PACD_DATA) |=> !sda_oe_ff) else $error("Acknowledge not released");

endmodule // pacd_top
`default_nettype wire

// [tb/pacd_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module pacd_host_model #(
  parameter int NVM_WAIT = 12500000
) (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [6:0] addr_in,
  input wire logic [7:0] cmd_in,
  input wire logic rd_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out,
  output logic done_out,
  output logic [1:0] ack_out
);
  logic a_ack;
  logic c_ack;

  // Idle bus: clock and data both released high between frames
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    done_out = 1'b0;
    ack_out = 2'b00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // One byte MSB first, ninth clock left released for the target's answer
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      scl_out <= 1'b0;
      tick(2);
      sda_out <= (i == 0) ? 1'b1 : b[i-1];
      tick(2);
      scl_out <= 1'b1;
      tick(4);
    end
    ack = (sda_in === 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Frame: start, address, command byte or a released read byte, stop
  always begin
    @(posedge clk_in);
    if (go_in === 1'b1) begin
      a_ack = 1'b0;
      c_ack = 1'b0;
      if (!((addr_in < 7'h0D) || (addr_in == 7'h4B) || (addr_in == 7'h61) || (addr_in > 7'h77))) begin
        sda_out <= 1'b0;
        tick(4);
        send_byte({addr_in, rd_in}, a_ack);
        if (a_ack) begin
          send_byte(rd_in ? 8'hFF : cmd_in, c_ack);
        end
        scl_out <= 1'b0;
        tick(2);
        sda_out <= 1'b0;
        tick(2);
        scl_out <= 1'b1;
        tick(4);
        sda_out <= 1'b1;
        tick(8);
        if (c_ack && (cmd_in inside {8'h11, 8'h12, 8'h15, 8'h16})) begin
          tick(NVM_WAIT);
        end
      end
      ack_out <= {c_ack, a_ack};
      done_out <= 1'b1;
      tick(1);
      done_out <= 1'b0;
    end
  end
endmodule // pacd_host_model
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [255:0] SUP_MAP =
    256'h3C09_07F7_71FF_0000_8001_0000_7F30_3901_7F00_0033_47FF_8873_038C_01FF_0066_000E;
  localparam int NVM_WAIT = 400;
  logic clk, rst, cyc, stb, we, ack, irq, scl, sda_host, sda_o, sda_oe, cmd_valid, user_store, go, h_done, sup, ad;
  logic [3:0] adr, mk, st;
  logic [31:0] wdat, rdat, q;
  logic [1:0] strap_lo, strap_hi, h_ack;
  logic [7:0] cmd_code, code, h_cmd;
  logic [6:0] h_addr;
  logic h_rd;
  int bad_count, comparisons, n_valid, n_store, v0, s0;
  logic [7:0] corner [21] = '{8'h00, 8'h10, 8'h35, 8'h01, 8'h03, 8'h78, 8'h79, 8'h88, 8'h11, 8'h12, 8'h15,
                              8'h16, 8'hEA, 8'hF3, 8'hFA, 8'hF2, 8'hBE, 8'hBC, 8'hBD, 8'h4B, 8'h47};
  wire logic sda_wire;

  // Pulled-up data line, low while the device pulls it
  assign sda_wire = sda_oe ? sda_o : sda_host;

  pacd_top i_dut (.CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
    .WB_SEL_IN(4'hF), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .IRQ_OUT(irq), .SCL_IN(scl),
    .SDA_IN(sda_wire), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .ADDR_STRAP_LOW_PIN_IN(strap_lo),
    .ADDR_STRAP_HIGH_PIN_IN(strap_hi), .CMD_VALID_OUT(cmd_valid), .CMD_CODE_OUT(cmd_code),
    .USER_STORE_OUT(user_store));

  pacd_host_model #(.NVM_WAIT(NVM_WAIT)) i_host (.clk_in(clk), .go_in(go), .addr_in(h_addr), .cmd_in(h_cmd),
    .rd_in(h_rd), .sda_in(sda_wire), .scl_out(scl), .sda_out(sda_host), .done_out(h_done), .ack_out(h_ack));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (cmd_valid === 1'b1) n_valid <= n_valid + 1;
    if (user_store === 1'b1) n_store <= n_store + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Expectations and bus tasks
  function automatic logic exp_sup(input logic [7:0] c, input logic a);
    if (c inside {8'hF2, 8'hBE}) return !a;
    if (c inside {8'hBC, 8'hBD}) return a;
    return SUP_MAP[c];
  endfunction

  function automatic logic [1:0] pin_of(input int lv);
    return (lv == 0) ? 2'b01 : (lv == 1) ? 2'b00 : 2'b10;
  endfunction

  function automatic logic [7:0] info_of(input int lo, input int hi);
    return {!(lo == 2 && hi == 2), 7'(7'h20 + 3 * hi + lo)};
  endfunction

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic tally_and_finish();
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) chk(1'b0, "bus ack missing");
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input string m);
    wb(1'b0, a, 32'h0000_0000);
    chk(q === e, m);
  endtask

  task automatic do_reset(input logic [1:0] lo, input logic [1:0] hi);
    @(posedge clk);
    strap_lo <= lo;
    strap_hi <= hi;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic frame(input logic [6:0] a, input logic [7:0] c, input logic r);
    int n;
    n = 0;
    @(posedge clk);
    h_addr <= a;
    h_cmd <= c;
    h_rd <= r;
    go <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (h_done !== 1'b1 && n < 3000);
    go <= 1'b0;
    if (n >= 3000) chk(1'b0, "host frame stuck");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, cyc, stb, we, go} = 5'h1F & 5'h10;
    {adr, wdat, strap_lo, strap_hi, h_addr, h_cmd, h_rd} = '0;
    void'($urandom(77004));
    do_reset(2'b00, 2'b00);
    rd_chk(pacd_pkg::REG_STATUS, 32'h0000_0000, "status reset");
    rd_chk(pacd_pkg::REG_MASK, 32'h0000_0000, "mask reset");
    rd_chk(pacd_pkg::REG_CTRL, 32'h0000_0001, "control reset");
    rd_chk(4'h2, 32'h0000_0000, "unmapped read");
    for (int hi = 0; hi < 3; hi++) begin
      for (int lo = 0; lo < 3; lo++) begin
        do_reset(pin_of(lo), pin_of(hi));
        rd_chk(pacd_pkg::REG_INFO, {24'h00_0000, info_of(lo, hi)}, "strap address");
        if (hi == 2) begin
          wb(1'b1, pacd_pkg::REG_CTRL, 32'h0000_0005);
          rd_chk(pacd_pkg::REG_INFO, {24'h00_0000, info_of(lo, 1)}, "missing high strap");
        end
      end
    end
    do_reset(2'b00, 2'b00);
    frame(7'h30, 8'h01, 1'b0);
    chk(h_ack === 2'b00, "foreign address answered");
    frame(7'h24, 8'h00, 1'b1);
    chk(h_ack === 2'b01, "read direction answer");
    chk(n_valid == 0, "read direction command");
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 33; i++) begin
        code = (i < 21) ? corner[i] : 8'($urandom);
        ad = p[0];
        mk = 4'($urandom);
        wb(1'b1, pacd_pkg::REG_CTRL, {30'h0000_0000, ad, 1'b1});
        wb(1'b1, pacd_pkg::REG_MASK, {28'h000_0000, mk});
        v0 = n_valid;
        s0 = n_store;
        frame(7'h24, code, 1'b0);
        sup = exp_sup(code, ad);
        st = {sup, sup && (code inside {8'h12, 8'h16}), sup && (code inside {8'h11, 8'h15}), !sup};
        chk(h_ack === {sup, 1'b1}, "command answer");
        chk(n_valid - v0 == (sup ? 1 : 0), "command pulse");
        chk(n_store - s0 == ((sup && code == 8'h15) ? 1 : 0), "user store pulse");
        chk(!sup || cmd_code === code, "command code");
        rd_chk(pacd_pkg::REG_STATUS, {28'h000_0000, st}, "status bits");
        chk(irq === |(st & mk), "interrupt level");
        wb(1'b1, pacd_pkg::REG_STATUS, 32'h0000_000F);
        rd_chk(pacd_pkg::REG_STATUS, 32'h0000_0000, "status clear");
        chk(irq === 1'b0, "interrupt clear");
      end
    end
    wb(1'b1, pacd_pkg::REG_CTRL, 32'h0000_0000);
    frame(7'h24, 8'h01, 1'b0);
    chk(h_ack === 2'b00, "disabled device answered");
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge clk);
    chk(1'b0, "watchdog expired");
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
